/* File: core/can_filter_mask_select.sv */
// extended identifier filter values, mask source selection and acceptance compare
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1 - a filter bit set to one needs the received bit to be one
// RULE2 - a filter bit set to zero needs the received bit to be zero
// RULE3 - sixteen read/write 16-bit extended identifier value registers, one per filter
// RULE4 - low select register: filters 0..7, two bits each, filter 7 on top, reset clear
// RULE5 - high select register: filters 8..15, two bits each, filter 15 on top, reset clear
// RULE6 - field code 00, 01, 10 picks mask set 0, 1, 2; 11 is reserved
// RULE7 - a filter matches when every mask-compared bit equals its programmed bit
module can_filter_mask_select
  import can_filter_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // register port
  input wire logic [ADDR_WIDTH-1:0] reg_addr_in,
  input wire logic [DATA_WIDTH-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [DATA_WIDTH-1:0] reg_rdata_out,
  // acceptance mask sets, one bit per identifier bit, one means compared
  input wire logic [ID_WIDTH-1:0] mask_set0_in,
  input wire logic [ID_WIDTH-1:0] mask_set1_in,
  input wire logic [ID_WIDTH-1:0] mask_set2_in,
  // received message identifier
  input wire logic rx_valid_in,
  input wire logic [ID_WIDTH-1:0] rx_ext_id_in,
  // acceptance result
  output logic match_valid_out,
  output logic [FILTER_COUNT-1:0] match_vec_out,
  output logic match_hit_out,
  output logic [INDEX_WIDTH-1:0] match_index_out
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [FILTER_COUNT-1:0][ID_WIDTH-1:0] ext_id_match_bits;
    logic [DATA_WIDTH-1:0] filter_mask_select_low;
    logic [DATA_WIDTH-1:0] filter_mask_select_high;
    logic [DATA_WIDTH-1:0] rdata;
    logic match_valid;
    logic [FILTER_COUNT-1:0] match_vec;
    logic match_hit;
    logic [INDEX_WIDTH-1:0] match_index;
  } state_t;

  state_t state_q;
  state_t state_d;

  // ==========================================================================
  // per filter mask selection and compare
  logic [FILTER_COUNT-1:0] filter_hit;
  logic [FILTER_COUNT*SEL_WIDTH-1:0] sel_all;

  assign sel_all = {state_q.filter_mask_select_high, state_q.filter_mask_select_low}; // RULE4

  genvar gi;
  generate
    for (gi = 0; gi < FILTER_COUNT; gi++) begin : g_filter
      mask_src_t src;
      logic [ID_WIDTH-1:0] mask;
      logic mask_ok;
      // field of filter n sits at bits 2n+1:2n across the two select registers
      assign src = mask_src_t'(sel_all[gi*SEL_WIDTH +: SEL_WIDTH]); // RULE5
      always_comb begin
        mask = mask_set0_in;
        mask_ok = 1'h1;
        unique case (src) // RULE6
          MASK_SET0: mask = mask_set0_in;
          MASK_SET1: mask = mask_set1_in;
          MASK_SET2: mask = mask_set2_in;
          MASK_RSVD: mask_ok = 1'h0;
        endcase
      end
      // compared bits must equal the programmed ones and zeros exactly
      assign filter_hit[gi] = mask_ok
        && (((rx_ext_id_in ^ state_q.ext_id_match_bits[gi]) & mask) == '0); // RULE1 RULE2 RULE7
    end
  endgenerate

  // ==========================================================================
  // lowest matching filter
  logic [INDEX_WIDTH-1:0] first_index;

  always_comb begin
    first_index = '0;
    for (int i = FILTER_COUNT - 1; i >= 0; i--) begin
      if (filter_hit[i]) begin
        first_index = INDEX_WIDTH'(i);
      end
    end
  end

  // ==========================================================================
  // register access
  logic [INDEX_WIDTH-1:0] id_index;
  logic id_sel;

  assign id_index = reg_addr_in[INDEX_WIDTH-1:0];
  // identifier registers fill the lower half of the map, so the top address bit decides
  assign id_sel = (reg_addr_in[ADDR_WIDTH-1:INDEX_WIDTH]
    == EXT_ID_BASE_ADDR[ADDR_WIDTH-1:INDEX_WIDTH]);

  always_comb begin
    state_d = state_q;
    // writes
    if (reg_write_in) begin
      if (id_sel) begin
        state_d.ext_id_match_bits[id_index] = reg_wdata_in; // RULE3
      end else if (reg_addr_in == SEL_LOW_ADDR) begin
        state_d.filter_mask_select_low = reg_wdata_in; // RULE4
      end else if (reg_addr_in == SEL_HIGH_ADDR) begin
        state_d.filter_mask_select_high = reg_wdata_in; // RULE5
      end
    end
    // reads land one cycle later; unmapped addresses read zero
    state_d.rdata = READ_ZERO;
    if (reg_read_in) begin
      if (id_sel) begin
        state_d.rdata = state_q.ext_id_match_bits[id_index]; // RULE3
      end else if (reg_addr_in == SEL_LOW_ADDR) begin
        state_d.rdata = state_q.filter_mask_select_low;
      end else if (reg_addr_in == SEL_HIGH_ADDR) begin
        state_d.rdata = state_q.filter_mask_select_high;
      end
    end
    // acceptance result, one cycle after the received identifier
    state_d.match_valid = rx_valid_in;
    if (rx_valid_in) begin
      state_d.match_vec = filter_hit; // RULE7
      state_d.match_hit = |filter_hit;
      state_d.match_index = first_index;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q.ext_id_match_bits <= {FILTER_COUNT{EXT_ID_RESET}};
      state_q.filter_mask_select_low <= SEL_RESET; // RULE4
      state_q.filter_mask_select_high <= SEL_RESET; // RULE5
      state_q.rdata <= READ_ZERO;
      state_q.match_valid <= 1'h0;
      state_q.match_vec <= '0;
      state_q.match_hit <= 1'h0;
      state_q.match_index <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // outputs
  assign reg_rdata_out = state_q.rdata;
  assign match_valid_out = state_q.match_valid;
  assign match_vec_out = state_q.match_vec;
  assign match_hit_out = state_q.match_hit;
  assign match_index_out = state_q.match_index;

endmodule : can_filter_mask_select

`default_nettype wire

/* File: core/can_filter_pkg.sv */
// constants, register map and encodings for the filter identifier and mask select block
package can_filter_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned FILTER_COUNT = 16;
  localparam int unsigned ID_WIDTH = 16;
  localparam int unsigned SEL_WIDTH = 2;
  localparam int unsigned FILTERS_PER_SEL = 8;
  localparam int unsigned ADDR_WIDTH = 5;
  localparam int unsigned DATA_WIDTH = 16;
  localparam int unsigned INDEX_WIDTH = 4;

  // ==========================================================================
  // register map (word addresses)
  localparam logic [ADDR_WIDTH-1:0] EXT_ID_BASE_ADDR = 5'h00;
  localparam logic [ADDR_WIDTH-1:0] EXT_ID_LAST_ADDR = 5'h0F;
  localparam logic [ADDR_WIDTH-1:0] SEL_LOW_ADDR = 5'h10;
  localparam logic [ADDR_WIDTH-1:0] SEL_HIGH_ADDR = 5'h11;

  // ==========================================================================
  // reset values
  localparam logic [ID_WIDTH-1:0] EXT_ID_RESET = 16'h0000;
  localparam logic [DATA_WIDTH-1:0] SEL_RESET = 16'h0000;
  localparam logic [DATA_WIDTH-1:0] READ_ZERO = 16'h0000;

  // ==========================================================================
  // mask source field encoding
  typedef enum logic [SEL_WIDTH-1:0] {
    MASK_SET0 = 2'h0,
    MASK_SET1 = 2'h1,
    MASK_SET2 = 2'h2,
    MASK_RSVD = 2'h3
  } mask_src_t;

endpackage : can_filter_pkg

/* File: verification/can_filter_monitor.sv */
// checker for the compare result and register read ports
`timescale 1ns/1ps
`default_nettype none
module can_filter_monitor
  import can_filter_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [ADDR_WIDTH-1:0] reg_addr_in,
  input wire logic reg_read_in,
  input wire logic [DATA_WIDTH-1:0] reg_rdata_out,
  input wire logic rx_valid_in,
  input wire logic match_valid_out,
  input wire logic [FILTER_COUNT-1:0] match_vec_out,
  input wire logic match_hit_out,
  input wire logic [INDEX_WIDTH-1:0] match_index_out
);
  // ==========================================================================
  // properties
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_take; rx_valid_in; endsequence
  sequence s_answer; match_valid_out; endsequence
  a_valid_after_rx: assert property (s_take |=> s_answer) else $error("match_valid late");
  a_valid_quiet: assert property (!rx_valid_in |=> !match_valid_out) else $error("stray valid");
  a_result_holds: assert property (!rx_valid_in |=> $stable(match_vec_out)) else $error("vec moved");
  a_hit_is_or: assert property (match_hit_out == (|match_vec_out)) else $error("hit wrong");
  a_index_lowest: assert property (match_hit_out |-> match_vec_out[match_index_out] &&
    ((match_vec_out & ((16'h1 << match_index_out) - 16'h1)) == 16'h0)) else $error("index");
  a_index_none: assert property (!match_hit_out |-> match_index_out == 4'h0) else $error("idx");
  a_rdata_idle: assert property (!reg_read_in |=> reg_rdata_out == READ_ZERO) else $error("rd");
  a_unmapped_zero: assert property (reg_read_in && reg_addr_in > SEL_HIGH_ADDR |=>
    reg_rdata_out == READ_ZERO) else $error("unmapped read not zero");
endmodule : can_filter_monitor
`default_nettype wire

/* File: verification/tb_top.sv */
// testbench for the filter identifier and mask select block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import can_filter_pkg::*;
;
  logic clk = 1'h0, rstn = 1'h0, we = 1'h0, re = 1'h0, rxv = 1'h0, mv, hit;
  logic [4:0] addr = 5'h00;
  logic [15:0] wd = 16'h0000, m0 = 16'hFFFF, m1 = 16'h00FF, m2 = 16'h0000, rxid = 16'h0000;
  logic [15:0] rdata, vec, e;
  logic [3:0] idx, ei;
  logic [15:0] ids [16];
  logic [31:0] sel = 32'h1B1BE4E4;
  int errors = 0, checks_done = 0;
  initial forever #12.5 clk = ~clk;
  can_filter_mask_select can_filter_mask_select_inst (.sys_clk_in(clk), .rstn_in(rstn),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_write_in(we), .reg_read_in(re),
    .reg_rdata_out(rdata), .mask_set0_in(m0), .mask_set1_in(m1), .mask_set2_in(m2),
    .rx_valid_in(rxv), .rx_ext_id_in(rxid), .match_valid_out(mv), .match_vec_out(vec),
    .match_hit_out(hit), .match_index_out(idx));
  // ==========================================================================
  // shared tasks
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk) {we, addr, wd} <= {1'h1, a, d};
    @(posedge clk) we <= 1'h0;
  endtask : wr
  task rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk) {re, addr} <= {1'h1, a};
    @(posedge clk) re <= 1'h0;
    #1 chk("reg_rdata_out", exp, rdata);
  endtask : rd
  task cmp(input logic [15:0] rx);
    @(posedge clk) {rxv, rxid} <= {1'h1, rx};
    @(posedge clk) rxv <= 1'h0;
    #1 e = 16'h0000;
    for (int n = 0; n < 16; n++) begin
      case (sel[2*n+:2])
        2'h0: e[n] = ((rx ^ ids[n]) & m0) == 16'h0;
        2'h1: e[n] = ((rx ^ ids[n]) & m1) == 16'h0;
        2'h2: e[n] = ((rx ^ ids[n]) & m2) == 16'h0;
        default: e[n] = 1'h0;
      endcase
    end
    chk("match_valid_out", 16'h1, {15'h0, mv});
    chk("match_vec_out", e, vec);
    chk("match_hit_out", {15'h0, |e}, {15'h0, hit});
    // lowest accepting filter, zero when none accepts
    ei = 4'h0;
    for (int n = 15; n >= 0; n--) begin
      if (e[n]) ei = 4'(n);
    end
    chk("match_index_out", {12'h0, ei}, {12'h0, idx});
  endtask : cmp
  task give_verdict();
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  // ==========================================================================
  // scenarios
  task t_regs();
    rd(SEL_LOW_ADDR, SEL_RESET);
    rd(SEL_HIGH_ADDR, SEL_RESET);
    for (int n = 0; n < 16; n++) begin
      ids[n] = 16'h1234 ^ (16'h1 << n);
      wr(5'(n), ids[n]);
    end
    for (int n = 0; n < 16; n++) rd(5'(n), ids[n]);
    wr(5'h12, 16'hFFFF);
    rd(5'h12, READ_ZERO);
    $display("t_regs done");
  endtask : t_regs
  task t_match();
    wr(SEL_LOW_ADDR, sel[15:0]);
    wr(SEL_HIGH_ADDR, sel[31:16]);
    rd(SEL_LOW_ADDR, sel[15:0]);
    rd(SEL_HIGH_ADDR, sel[31:16]);
    cmp(16'h1234);
    cmp(ids[5]);
    cmp(ids[9]);
    @(posedge clk) m1 <= 16'hFF00;
    cmp(16'h1234);
    // every set compares all bits: no filter value equals this identifier
    @(posedge clk) {m1, m2} <= {16'hFFFF, 16'hFFFF};
    cmp(16'h1234);
    $display("t_match done");
  endtask : t_match
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_match();
    give_verdict();
  end
endmodule : tb_top
bind can_filter_mask_select can_filter_monitor can_filter_monitor_inst (.sys_clk_in(sys_clk_in),
  .rstn_in(rstn_in), .reg_addr_in(reg_addr_in), .reg_read_in(reg_read_in),
  .reg_rdata_out(reg_rdata_out), .rx_valid_in(rx_valid_in), .match_valid_out(match_valid_out),
  .match_vec_out(match_vec_out), .match_hit_out(match_hit_out), .match_index_out(match_index_out));
`default_nettype wire
